// File: hdl/twrs_pkg.sv
// Package of constants shared by the two-wire register slave.
package twrs_pkg;
  localparam logic [6:0] ADDR_DEFAULT = 7'h10;
  localparam logic [6:0] ADDR_ALT = 7'h18;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_PRE = 4'hf;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [6:0] PROG_ADDR_RESET = 7'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  typedef enum logic [2:0] {
    TWRS_IDLE,
    TWRS_DEV,
    TWRS_ADDR_HI,
    TWRS_ADDR_LO,
    TWRS_WDATA,
    TWRS_RDATA,
    TWRS_IGNORE
  } twrs_state_t;
endpackage

// File: hdl/twrs_sync.sv
// Two flip-flop synchroniser for a level moving into another clock domain.
module twrs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  // The first stage is read only by the second, so no logic sees a metastable value.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_o <= '1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// File: hdl/twrs_slave.sv
// Two-wire serial register slave with address matching, pointer and byte exchange.
// Sampling scheme.
// The bus pins are oversampled on ref_clk_i rather than clocked directly.
// Both bus pins pass one shared two-stage synchroniser.
// Sharing the stages keeps the clock and data samples aligned in time.
// A third register per pin gives the edge detectors their previous value.
// A clock edge or a condition is therefore seen about three cycles late.
// Each bus clock phase must last at least four ref_clk_i cycles.
// A shorter phase could be missed between two samples.
//
// Bit counting.
// A start parks the bit counter at a pre-byte value.
// The falling clock that closes the start moves it to the first bit.
// Without that park the closing fall would be counted as a data bit.
// Bits are shifted in on the rising clock, most significant first.
// The falling clock after the eighth bit opens the acknowledge slot.
// The falling clock after the acknowledge slot starts the next byte.
// A stop returns the counter to the first bit and idles the machine.
//
// Byte sequence.
// The first byte after a start holds the seven address bits and the direction.
// On a match the slave drives the acknowledge; otherwise it ignores the frame.
// A write frame carries the high address byte, the low address byte, then data.
// Each data byte of a write raises one write strobe toward the register file.
// The strobe carries the pointer value from before its increment.
// A read frame sends data bytes from the pointer until the master refuses one.
// A refused read byte sends the machine to the ignore state until a start or a stop.
// A repeated start is taken like any start, so a dummy write can precede a read.
//
// Pointer.
// The pointer keeps its value across frames, so a read may omit the address.
// It steps by one at the end of every data byte in either direction.
// A frame cut short inside the address bytes may leave half a new address.
// That matches the usual behaviour of such ports and keeps the logic small.
//
// Read data path.
// The register file answers combinationally at reg_addr_o.
// The most significant bit is taken straight from the read data at the slot end.
// The full byte is then captured while the clock is high in the first bit.
// The later bits are shifted out of that copy on each falling clock.
// Capturing only outside a falling clock keeps the load and the shift apart.
//
// Line driver.
// The pad is open drain, so only the enable carries information.
// The enable is only set just after a detected falling clock.
// A start or a stop always releases the line at once.
// The external pull-up returns the line high whenever the enable is low.
//
// Address choice.
// The select input picks the alternate pair only while its enable is high.
// A programmed address of zero means that no extra address is matched.
// The programmed address passes two stages before the comparator reads it.
// A change of the programmed address during a frame can cause one bad compare.
// Software is expected to change it only while the bus is idle.
//
// Limitations.
// There is no clock stretching, so the register file must answer in one cycle.
// There is no general call and no ten-bit addressing.
// Bus timing checks such as setup and hold are left to the pads.
// A glitch on the bus clock shorter than a sample period is not filtered.
// Such a glitch may be counted as an extra bit and corrupt one byte.
// Trading a filter for latency kept the acknowledge response quick.
//
// Reset.
// Reset returns the machine to idle, the pointer to zero and the line released.
// The synchronisers reset to the idle high level, so no false start follows.
// Bus activity is accepted three ref_clk_i cycles after reset is released.
module twrs_slave (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  input wire logic address_select_input_i,
  input wire logic address_select_enable_i,
  input wire logic prog_addr_enable_i,
  input wire logic [6:0] prog_addr_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_write_o
);
  // The bus runs at the master's pace on ref_clk_i; 50 MHz oversamples it well.
  // The ports serial_clock_i and serial_data_line_i come from pins and are synchronised first.
  logic [1:0] pins_s;
  logic scl_r, sda_r;
  logic [1:0] cfg_s;
  logic [6:0] prog_meta_r, prog_addr_r;
  twrs_pkg::twrs_state_t state_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [15:0] ptr_r;
  logic read_r;
  logic nack_r;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [6:0] my_addr;
  logic addr_hit;

  twrs_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({serial_clock_i, serial_data_line_i}),
    .q_o(pins_s)
  );

  twrs_sync #(.WIDTH(2)) u_cfg_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({address_select_input_i, address_select_enable_i}),
    .q_o(cfg_s)
  );

  // Delayed copies of the synchronised pins give the edge detectors a previous value.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= pins_s[1];
      sda_r <= pins_s[0];
    end
  end

  // Masks the programmed address to zero while it is disabled.
  function automatic logic [6:0] prog_enable_mask(input logic [6:0] a, input logic en);
    prog_enable_mask = en ? a : twrs_pkg::PROG_ADDR_RESET;
  endfunction

  // Programmed address may change at any time; two stages keep it quiet before use.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_meta_r <= twrs_pkg::PROG_ADDR_RESET;
      prog_addr_r <= twrs_pkg::PROG_ADDR_RESET;
    end else begin
      prog_meta_r <= prog_enable_mask(prog_addr_i, prog_addr_enable_i);
      prog_addr_r <= prog_meta_r;
    end
  end

  // Edge and condition detection on the clean copies of the bus.
  assign scl_rise = pins_s[1] & ~scl_r;
  assign scl_fall = ~pins_s[1] & scl_r;
  assign start_det = pins_s[1] & scl_r & sda_r & ~pins_s[0];
  assign stop_det = pins_s[1] & scl_r & ~sda_r & pins_s[0];

  // Address chosen by the select input, with the programmed one as an extra match.
  assign my_addr = (cfg_s[0] & cfg_s[1]) ? twrs_pkg::ADDR_ALT : twrs_pkg::ADDR_DEFAULT;
  assign addr_hit = (shift_r[7:1] == my_addr) |
                    ((prog_addr_r != twrs_pkg::PROG_ADDR_RESET) && (shift_r[7:1] == prog_addr_r));

  // Bit counter: eight data bits then the acknowledge slot, counted on clock edges.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_r <= twrs_pkg::BIT_FIRST;
    end else if (start_det) begin
      bit_r <= twrs_pkg::BIT_PRE;
    end else if (stop_det) begin
      bit_r <= twrs_pkg::BIT_FIRST;
    end else if (scl_fall) begin
      // The fall that closes a start is not a data bit.
      if (bit_r == twrs_pkg::BIT_ACK || bit_r == twrs_pkg::BIT_PRE) begin
        bit_r <= twrs_pkg::BIT_FIRST;
      end else begin
        bit_r <= bit_r + 4'h1;
      end
    end
  end

  // Shift in MSB first on every rising clock of a data bit.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r <= twrs_pkg::BYTE_ZERO;
    end else if (scl_rise && bit_r != twrs_pkg::BIT_ACK) begin
      shift_r <= {shift_r[6:0], pins_s[0]};
    end
  end

  // Master's acknowledge after a read byte is sampled on the rising clock of the slot.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nack_r <= 1'b0;
    end else if (start_det) begin
      nack_r <= 1'b0;
    end else if (scl_rise && bit_r == twrs_pkg::BIT_ACK && state_r == twrs_pkg::TWRS_RDATA) begin
      nack_r <= pins_s[0];
    end
  end

  // Protocol state machine, advancing at the falling clock that ends each acknowledge slot; a missed address leaves one fall earlier.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= twrs_pkg::TWRS_IDLE;
      read_r <= 1'b0;
    end else if (start_det) begin
      state_r <= twrs_pkg::TWRS_DEV;
    end else if (stop_det) begin
      state_r <= twrs_pkg::TWRS_IDLE;
    end else if (scl_fall && bit_r == twrs_pkg::BIT_LAST) begin
      case (state_r)
        twrs_pkg::TWRS_DEV: begin
          if (!addr_hit) begin
            state_r <= twrs_pkg::TWRS_IGNORE;
          end
          read_r <= shift_r[0];
        end
        default: begin
        end
      endcase
    end else if (scl_fall && bit_r == twrs_pkg::BIT_ACK) begin
      case (state_r)
        twrs_pkg::TWRS_DEV: begin
          state_r <= read_r ? twrs_pkg::TWRS_RDATA : twrs_pkg::TWRS_ADDR_HI;
        end
        twrs_pkg::TWRS_ADDR_HI: begin
          state_r <= twrs_pkg::TWRS_ADDR_LO;
        end
        twrs_pkg::TWRS_ADDR_LO: begin
          state_r <= twrs_pkg::TWRS_WDATA;
        end
        twrs_pkg::TWRS_WDATA: begin
          state_r <= twrs_pkg::TWRS_WDATA;
        end
        twrs_pkg::TWRS_RDATA: begin
          if (nack_r) begin
            state_r <= twrs_pkg::TWRS_IGNORE;
          end else begin
            state_r <= twrs_pkg::TWRS_RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Address pointer loads from the two address bytes and steps after every data byte.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_r <= twrs_pkg::PTR_RESET;
    end else if (scl_fall && bit_r == twrs_pkg::BIT_LAST && !start_det && !stop_det) begin
      case (state_r)
        twrs_pkg::TWRS_ADDR_HI: begin
          ptr_r <= {shift_r, ptr_r[7:0]};
        end
        twrs_pkg::TWRS_ADDR_LO: begin
          ptr_r <= {ptr_r[15:8], shift_r};
        end
        twrs_pkg::TWRS_WDATA, twrs_pkg::TWRS_RDATA: begin
          ptr_r <= ptr_r + twrs_pkg::PTR_STEP;
        end
        default: begin
        end
      endcase
    end
  end

  // Write strobe to the register file, one ref_clk_i cycle, with the pre-increment address.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_write_o <= 1'b0;
      reg_wdata_o <= twrs_pkg::BYTE_ZERO;
      reg_addr_o <= twrs_pkg::PTR_RESET;
    end else begin
      reg_write_o <= scl_fall && bit_r == twrs_pkg::BIT_LAST && state_r == twrs_pkg::TWRS_WDATA &&
                     !start_det && !stop_det;
      if (scl_fall && bit_r == twrs_pkg::BIT_LAST && state_r == twrs_pkg::TWRS_WDATA) begin
        reg_wdata_o <= shift_r;
        reg_addr_o <= ptr_r;
      end else if (state_r != twrs_pkg::TWRS_WDATA) begin
        reg_addr_o <= ptr_r; // Read data is looked up at the current pointer.
      end
    end
  end

  // Transmit byte is captured when a read byte begins; the register file answers within a cycle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_r <= twrs_pkg::BYTE_ZERO;
    end else if (state_r == twrs_pkg::TWRS_RDATA && bit_r == twrs_pkg::BIT_FIRST && scl_r && !scl_fall) begin
      tx_r <= reg_rdata_i;
    end else if (state_r == twrs_pkg::TWRS_RDATA && scl_fall && bit_r != twrs_pkg::BIT_ACK) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Line driver: open drain, only low is ever driven, and only just after a falling clock.
  // Changing on the falling edge keeps the line steady through every high phase.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_data_line_oe_o <= 1'b0;
      serial_data_line_o <= 1'b0;
    end else if (start_det || stop_det) begin
      serial_data_line_oe_o <= 1'b0;
    end else if (scl_fall) begin
      serial_data_line_o <= 1'b0;
      if (bit_r == twrs_pkg::BIT_LAST) begin
        // Acknowledge slot as receiver; a transmitter releases here.
        case (state_r)
          twrs_pkg::TWRS_DEV: serial_data_line_oe_o <= addr_hit;
          twrs_pkg::TWRS_ADDR_HI, twrs_pkg::TWRS_ADDR_LO, twrs_pkg::TWRS_WDATA:
            serial_data_line_oe_o <= 1'b1;
          default: serial_data_line_oe_o <= 1'b0;
        endcase
      end else if (bit_r == twrs_pkg::BIT_ACK) begin
        // First read bit after an address match or a master acknowledge.
        if ((state_r == twrs_pkg::TWRS_DEV && read_r) || (state_r == twrs_pkg::TWRS_RDATA && !nack_r)) begin
          serial_data_line_oe_o <= ~reg_rdata_i[7];
        end else begin
          serial_data_line_oe_o <= 1'b0;
        end
      end else if (state_r == twrs_pkg::TWRS_RDATA) begin
        serial_data_line_oe_o <= ~tx_r[6];
      end else begin
        serial_data_line_oe_o <= 1'b0;
      end
    end
  end
endmodule

// File: tb/twrs_chk.sv
// Concurrent checks on the pins of the two-wire register slave.
module twrs_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe_o,
  input wire logic [15:0] reg_addr_o,
  input wire logic reg_write_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] wa_r;
  logic [8:0] gap_r;
  // Cycles since the last strobe; back-to-back data bytes are closer than 200.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wa_r <= 16'h0000;
      gap_r <= 9'h1ff;
    end else if (reg_write_o) begin
      wa_r <= reg_addr_o;
      gap_r <= 9'h000;
    end else if (gap_r != 9'h1ff) begin
      gap_r <= gap_r + 9'h001;
    end
  end
  // The pad is open drain, so only the enable may ever carry information.
  property p_odrain; serial_data_line_o == 1'b0; endproperty
  a_odrain: assert property (p_odrain) else $error("data out not low");
  // Drive changes only while the bus clock is low.
  property p_chg_low; $changed(serial_data_line_oe_o) |-> !serial_clock_i; endproperty
  a_chg_low: assert property (p_chg_low) else $error("drive changed with clock high");
  // A driven bit stands for at least eight ref_clk_i cycles after it rises.
  property p_hold; $rose(serial_data_line_oe_o) |-> serial_data_line_oe_o [*8]; endproperty
  a_hold: assert property (p_hold) else $error("drive too short");
  // Each strobe lasts a single ref_clk_i cycle.
  property p_wpulse; reg_write_o |=> !reg_write_o; endproperty
  a_wpulse: assert property (p_wpulse) else $error("write strobe too long");
  // The pointer steps by one between back-to-back written bytes.
  property p_winc; reg_write_o && gap_r < 9'd200 |-> reg_addr_o == wa_r + 16'h0001; endproperty
  a_winc: assert property (p_winc) else $error("pointer not incremented");
  // Every written byte is acknowledged.
  property p_wack; reg_write_o |-> ##[0:2] serial_data_line_oe_o; endproperty
  a_wack: assert property (p_wack) else $error("write byte not acked");
  // Leaving reset the pointer is zero and the line is released.
  property p_rst; $fell(rst_i) |-> reg_addr_o == 16'h0000 && !serial_data_line_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // A strobe never comes while the bus clock is high.
  property p_wlow; reg_write_o |-> !serial_clock_i; endproperty
  a_wlow: assert property (p_wlow) else $error("write strobe with clock high");
endmodule
bind twrs_slave twrs_chk u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .serial_clock_i(serial_clock_i),
  .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe_o(serial_data_line_oe_o),
  .reg_addr_o(reg_addr_o),
  .reg_write_o(reg_write_o)
);

// File: tb/twrs_master.sv
// Behavioural bus master that clocks the serial port from the link clock.
module twrs_master (
  input wire logic link_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 16;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One wait step: a whole bit high phase, half a bit low phase; 96 ns keeps each phase above the slave's oversampling floor.
  task automatic hw();
    repeat (H) @(negedge link_clk_i);
  endtask
  // Data changes only with the clock low and is sampled late in the high phase.
  task automatic sbit(input logic b, output logic r);
    sda_low_o = !b;
    hw();
    scl_o = 1'b1;
    hw();
    r = sda_i;
    scl_o = 1'b0;
    hw();
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    hw();
    scl_o = 1'b1;
    hw();
    sda_low_o = 1'b1;
    hw();
    scl_o = 1'b0;
    hw();
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    hw();
    scl_o = 1'b1;
    hw();
    sda_low_o = 1'b0;
    hw();
  endtask
  // Byte out MSB first, then the line is released for the acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(d[i], r);
    sbit(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then ack to continue or release to end the read.
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(1'b1, d[i]);
    sbit(!mack, r);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the two-wire register slave.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, link_clk = 1'b0, rst_i = 1'b1, sel = 1'b0, sel_en = 1'b0, pen = 1'b0;
  logic scl, m_low, oe, o, wr, a;
  logic [15:0] ra;
  logic [7:0] wd, d0, d1, r;
  logic [7:0] mem [256];
  logic [23:0] expq [$];
  int failures = 0, samples_checked = 0, seed = 32'h85ac6276;
  // Pull-up on the data line: low whenever either party drives.
  wire sda = !(oe || m_low);
  always #10 ref_clk_i = ~ref_clk_i;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  twrs_slave u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_clock_i(scl),
    .serial_data_line_i(sda), .serial_data_line_o(o), .serial_data_line_oe_o(oe),
    .address_select_input_i(sel), .address_select_enable_i(sel_en), .prog_addr_enable_i(pen),
    .prog_addr_i(7'h2a), .reg_rdata_i(mem[ra[7:0]]), .reg_addr_o(ra), .reg_wdata_o(wd), .reg_write_o(wr));
  twrs_master u_mst (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Each write strobe lands in the register model and is matched to the oldest note.
  always @(posedge ref_clk_i) begin
    if (wr) begin
      mem[ra[7:0]] <= wd;
      if (expq.size() == 0) chk("extra write", 24'h1, 24'h0);
      else chk("write", {ra, wd}, expq.pop_front());
    end
  end
  task automatic adr(input logic [6:0] sa, input logic rd, input logic e);
    u_mst.start();
    u_mst.wbyte({sa, rd}, a);
    chk("addr ack", a, e);
  endtask
  task automatic wb(input logic [7:0] d);
    u_mst.wbyte(d, a);
    chk("byte ack", a, 1'b1);
  endtask
  // A stuck bus ends the run as a failure.
  initial begin
    #1500000;
    failures++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rst_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    // Sequential write across a low-byte carry.
    d0 = $random(seed);
    d1 = $random(seed);
    expq.push_back({16'h12ff, d0});
    expq.push_back({16'h1300, d1});
    adr(7'h10, 1'b0, 1'b1);
    wb(8'h12);
    wb(8'hff);
    wb(d0);
    wb(d1);
    u_mst.stop();
    // Random-location read of both bytes, acked then released.
    adr(7'h10, 1'b0, 1'b1);
    wb(8'h12);
    wb(8'hff);
    adr(7'h10, 1'b1, 1'b1);
    u_mst.rbyte(1'b1, r);
    chk("read0", r, d0);
    u_mst.rbyte(1'b0, r);
    chk("read1", r, d1);
    u_mst.stop();
    // Current-location read continues from the pointer.
    adr(7'h10, 1'b1, 1'b1);
    u_mst.rbyte(1'b0, r);
    chk("cur read", r, 8'h01 ^ 8'h5a);
    u_mst.stop();
    // Foreign address: no ack, following byte ignored.
    adr(7'h11, 1'b0, 1'b0);
    u_mst.wbyte(8'h00, a);
    chk("ignored", a, 1'b0);
    u_mst.stop();
    // Alternate pair replaces the default only when enabled.
    for (int k = 0; k < 2; k++) begin
      @(negedge ref_clk_i) sel = 1'b1;
      sel_en = k[0];
      repeat (4) @(negedge ref_clk_i);
      adr(7'h18, 1'b0, k[0]);
      u_mst.stop();
      adr(7'h10, 1'b0, !k[0]);
      u_mst.stop();
    end
    // Programmed address answers only while enabled.
    @(negedge ref_clk_i) pen = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    adr(7'h2a, 1'b1, 1'b1);
    u_mst.rbyte(1'b0, r);
    chk("prog read", r, 8'h02 ^ 8'h5a);
    u_mst.stop();
    @(negedge ref_clk_i) pen = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    adr(7'h2a, 1'b0, 1'b0);
    u_mst.stop();
    chk("pending", expq.size(), 24'h0);
    finish_test();
  end
endmodule
